/* ccg_config_bank.sv */
// generic configuration byte bank of a programmable clock generator
//
// Functional notes
// - source select bit picks input clock (0) or first pll clock (1)
// - pin-function bit: 0 serial bus pins, 1 control pins S1 S2
// - control-pin use takes effect only once the bit is stored
// - grounded output supply forces serial pins and slave address zero
// - state code: 00 power down, 01 hi-z, 10 low, 11 enabled
// - state one at bits 5:4 resets 11, state zero at 3:2 resets 01
// - ten-bit output divider; zero means reset and standby
// - eight select bits indexed by control pins pick state zero or one
// - three control pins choose among eight stored control settings
// - five-bit load capacitor code at 7:3, resets 0Ah
// - seven-bit byte count sets bytes returned in a block read
// - store cycle starts only on rising edge of trigger bit
// - readable in-progress bit lets host poll store completion
// - no store cycle while the permanent lock is set
// - in-progress bit 6 of byte 01h high during store, else low
`timescale 1ns/1ps
module ccg_config_bank #(
  parameter int         STORE_CYCLES = ccg_pkg::NVM_STORE_CYCLES,
  parameter logic [4:0] ADDR_HI      = ccg_pkg::LINK_ADDR_HI
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       link_clk_i,
  input  wire logic       control_pin_zero_i,
  input  wire logic       shared_data_pin_i,
  output logic            shared_data_pin_o,
  output logic            shared_data_pin_oe_n_o,
  input  wire logic       shared_clk_pin_i,
  output logic            shared_clk_pin_o,
  output logic            shared_clk_pin_oe_n_o,
  input  wire logic       output_supply_gnd_i,
  output logic            first_output_source_sel_o,
  output logic [9:0]      first_output_divider_o,
  output logic            first_output_divider_standby_o,
  output logic            first_clock_output_enable_o,
  output logic            first_clock_output_hiz_o,
  output logic            first_clock_output_low_o,
  output logic            device_power_down_o,
  output logic [4:0]      crystal_load_code_o,
  output logic            shared_pin_function_sel_o,
  output logic            nvm_store_in_progress_o
);
  import ccg_pkg::*;

  localparam int CW = $clog2(STORE_CYCLES + 1);

  // ==========================================================
  // pin and toggle synchronisers
  // order: {req toggle, control pin zero, clk pin, data pin, supply gnd}
  localparam logic [4:0] SYNC_RST = 5'h06;
  logic [4:0] sy_q1, sy_q2, sy_q3, sy_s;
  ccg_req_s   link_req;
  logic       link_req_tgl;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sy_q1 <= SYNC_RST;
      sy_q2 <= SYNC_RST;
      sy_q3 <= SYNC_RST;
      sy_s  <= SYNC_RST;
    end else if (ce_i) begin
      sy_q1 <= {link_req_tgl, control_pin_zero_i, shared_clk_pin_i,
                shared_data_pin_i, output_supply_gnd_i};
      sy_q2 <= sy_q1;
      sy_q3 <= sy_q2;
      sy_s  <= ((sy_q2 ~^ sy_q3) & sy_q3) | ((sy_q2 ^ sy_q3) & sy_s);
    end
  end

  logic gnd_s;
  assign gnd_s = sy_s[0];

  // ==========================================================
  // register state
  logic       src_r, pinf_r, trig_r, lock_r, busy_r;
  logic [1:0] st1_r, st0_r, saddr_r;
  logic [9:0] div_r;
  logic [7:0] pinsel_r;
  logic [4:0] cap_r;
  logic [6:0] bcnt_r;
  logic       stored_pinf_r, stored_lock_r;
  logic [CW-1:0] store_cnt_r;

  // ==========================================================
  // request service from the link domain
  ccg_rsp_s  rsp_r;
  logic      rsp_tgl_r;
  logic      req_seen_r;
  logic      new_req, wr_en;
  logic [7:0] wr_addr, wr_data, rd_data;
  logic [6:0] blk_left_r, blk_now;

  assign new_req = ce_i && (sy_s[4] != req_seen_r);
  assign wr_en   = new_req && link_req.kind == CCG_WRITE;
  assign wr_addr = link_req.addr;
  assign wr_data = link_req.data;

  always_comb begin
    rd_data = 8'h00;
    case (link_req.addr)
      // in-progress flag readable for polling
      // status readback
      OFS_STATUS: rd_data = {1'b0, busy_r, lock_r, 3'h0, saddr_r};
      OFS_SRC:    rd_data = {src_r, pinf_r, st1_r, st0_r, div_r[9:8]};
      OFS_DIVLO:  rd_data = div_r[7:0];
      OFS_PINSEL: rd_data = pinsel_r;
      OFS_CAP:    rd_data = {cap_r, 3'h0};
      OFS_BCNT:   rd_data = {bcnt_r, trig_r};
      default:    rd_data = 8'h00;
    endcase
  end

  assign blk_now = (link_req.kind == CCG_READ_FIRST) ? bcnt_r : blk_left_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      req_seen_r <= 1'b0;
      rsp_tgl_r  <= 1'b0;
      rsp_r      <= '0;
      blk_left_r <= 7'h00;
    end else if (new_req) begin
      req_seen_r <= sy_s[4];
      rsp_tgl_r  <= ~rsp_tgl_r;
      if (link_req.kind != CCG_WRITE) begin
        rsp_r.data <= rd_data;
        rsp_r.more <= blk_now > 7'h01;
        blk_left_r <= (blk_now == 7'h00) ? 7'h00 : 7'(blk_now - 7'h01);
      end
    end
  end

  // ==========================================================
  // byte 02h and 03h: source, pin function, states, divider
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      src_r  <= RST_SRC;
      pinf_r <= RST_PINF;
      st1_r  <= RST_ST1;
      st0_r  <= RST_ST0;
      div_r  <= RST_DIV;
    end else if (wr_en && wr_addr == OFS_SRC) begin
      src_r      <= wr_data[BIT_SRC];
      pinf_r     <= wr_data[BIT_PINF];
      st1_r      <= wr_data[ST1_HI:ST1_LO];
      st0_r      <= wr_data[ST0_HI:ST0_LO];
      div_r[9:8] <= wr_data[DIVHI_HI:0];
    end else if (wr_en && wr_addr == OFS_DIVLO) begin
      div_r[7:0] <= wr_data;
    end
  end

  // ==========================================================
  // bytes 04h to 06h and the lock and address bits of 01h
  // reserved bits and bytes 07h up are dropped; zeros are expected
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pinsel_r <= RST_PINSEL;
      cap_r    <= RST_CAP;
      bcnt_r   <= RST_BCNT;
      trig_r   <= 1'b0;
      lock_r   <= 1'b0;
      saddr_r  <= 2'h0;
    end else if (wr_en) begin
      case (wr_addr)
        OFS_STATUS: begin
          lock_r  <= wr_data[BIT_LOCK];
          saddr_r <= wr_data[SADDR_HI:0];
        end
        OFS_PINSEL: pinsel_r <= wr_data;
        OFS_CAP:    cap_r <= wr_data[7:CAP_LO];
        OFS_BCNT: begin
          bcnt_r <= wr_data[7:BCNT_LO];
          trig_r <= wr_data[BIT_TRIG];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // nonvolatile store engine; only the pin-function and lock bits are kept
  logic store_start;
  assign store_start = wr_en && wr_addr == OFS_BCNT && wr_data[BIT_TRIG]
                       && !trig_r && !stored_lock_r && !busy_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      busy_r        <= 1'b0;
      store_cnt_r   <= '0;
      stored_pinf_r <= RST_PINF;
      stored_lock_r <= 1'b0;
    end else if (ce_i) begin
      if (store_start) begin
        busy_r      <= 1'b1;
        store_cnt_r <= CW'(STORE_CYCLES - 1);
      end else if (busy_r && store_cnt_r != '0) begin
        store_cnt_r <= CW'(store_cnt_r - 1'b1);
      end else if (busy_r) begin
        busy_r        <= 1'b0;
        stored_pinf_r <= pinf_r;
        stored_lock_r <= lock_r;
      end
    end
  end

  // ==========================================================
  // pin function and output state decode
  logic       ctrl_mode;
  logic [1:0] saddr_eff;
  logic [2:0] ctrl_idx;
  logic [1:0] st_def;

  // stored bit, overridden by grounded supply
  assign ctrl_mode = stored_pinf_r & ~gnd_s;
  assign saddr_eff = gnd_s ? 2'h0 : saddr_r;
  assign ctrl_idx  = ctrl_mode ? {sy_s[2], sy_s[1], sy_s[3]}
                               : {2'h0, sy_s[3]};
  assign st_def    = pinsel_r[ctrl_idx] ? st1_r : st0_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      first_output_source_sel_o      <= RST_SRC;
      first_output_divider_o         <= RST_DIV;
      first_output_divider_standby_o <= 1'b0;
      first_clock_output_enable_o    <= 1'b0;
      first_clock_output_hiz_o       <= 1'b1;
      first_clock_output_low_o       <= 1'b0;
      device_power_down_o            <= 1'b0;
      crystal_load_code_o            <= RST_CAP;
      shared_pin_function_sel_o      <= 1'b0;
      nvm_store_in_progress_o        <= 1'b0;
    end else if (ce_i) begin
      first_output_source_sel_o      <= src_r;
      first_output_divider_o         <= div_r;
      first_output_divider_standby_o <= div_r == 10'h000;
      device_power_down_o            <= st_def == STDEF_PWRDN;
      first_clock_output_hiz_o       <= st_def == STDEF_PWRDN
                                        || st_def == STDEF_HIZ;
      first_clock_output_low_o       <= st_def == STDEF_LOW;
      first_clock_output_enable_o    <= st_def == STDEF_ON;
      // capacitance above 20 pF saturates in the analog trim
      crystal_load_code_o            <= cap_r;
      shared_pin_function_sel_o      <= ctrl_mode;
      nvm_store_in_progress_o        <= busy_r;
    end
  end

  // ==========================================================
  // link side; levels registered so the crossing sees no glitches
  logic [2:0] link_lvl_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      link_lvl_r <= 3'h1;
    end else if (ce_i) begin
      link_lvl_r <= {saddr_eff, ~ctrl_mode};
    end
  end

  ccg_serial_link #(
    .ADDR_HI (ADDR_HI)
  ) u_link (
    .link_clk_i      (link_clk_i),
    .rst_i           (rst_i),
    .ce_i            (ce_i),
    .serial_en_i     (link_lvl_r[0]),
    .slave_addr_lo_i (link_lvl_r[2:1]),
    .sda_i           (shared_data_pin_i),
    .scl_i           (shared_clk_pin_i),
    .sda_o           (shared_data_pin_o),
    .sda_oe_n_o      (shared_data_pin_oe_n_o),
    .scl_o           (shared_clk_pin_o),
    .scl_oe_n_o      (shared_clk_pin_oe_n_o),
    .req_o           (link_req),
    .req_tgl_o       (link_req_tgl),
    .rsp_i           (rsp_r),
    .rsp_tgl_i       (rsp_tgl_r)
  );

endmodule

/* ccg_pkg.sv */
// shared constants and carrier types for the clock generator config bank
package ccg_pkg;

  // ==========================================================
  // timing
  localparam int SYS_CLK_MHZ       = 50;
  localparam int NVM_STORE_TIME_US = 2000;
  localparam int NVM_STORE_CYCLES  = NVM_STORE_TIME_US * SYS_CLK_MHZ;

  // ==========================================================
  // byte offsets
  localparam logic [7:0] OFS_STATUS  = 8'h01;
  localparam logic [7:0] OFS_SRC     = 8'h02;
  localparam logic [7:0] OFS_DIVLO   = 8'h03;
  localparam logic [7:0] OFS_PINSEL  = 8'h04;
  localparam logic [7:0] OFS_CAP     = 8'h05;
  localparam logic [7:0] OFS_BCNT    = 8'h06;

  // ==========================================================
  // field positions
  localparam int BIT_SRC   = 7;
  localparam int BIT_PINF  = 6;
  localparam int ST1_HI    = 5;
  localparam int ST1_LO    = 4;
  localparam int ST0_HI    = 3;
  localparam int ST0_LO    = 2;
  localparam int DIVHI_HI  = 1;
  localparam int CAP_LO    = 3;
  localparam int BCNT_LO   = 1;
  localparam int BIT_TRIG  = 0;
  localparam int BIT_BUSY  = 6;
  localparam int BIT_LOCK  = 5;
  localparam int SADDR_HI  = 1;

  // ==========================================================
  // reset values
  localparam logic       RST_SRC    = 1'b1;
  localparam logic       RST_PINF   = 1'b0;
  localparam logic [1:0] RST_ST1    = 2'h3;
  localparam logic [1:0] RST_ST0    = 2'h1;
  localparam logic [9:0] RST_DIV    = 10'h001;
  localparam logic [7:0] RST_PINSEL = 8'h02;
  localparam logic [4:0] RST_CAP    = 5'h0A;
  localparam logic [6:0] RST_BCNT   = 7'h50;

  // ==========================================================
  // output state definitions
  localparam logic [1:0] STDEF_PWRDN = 2'h0;
  localparam logic [1:0] STDEF_HIZ   = 2'h1;
  localparam logic [1:0] STDEF_LOW   = 2'h2;
  localparam logic [1:0] STDEF_ON    = 2'h3;

  // ==========================================================
  // serial link
  localparam logic [3:0] LINK_BITS   = 4'h8;
  localparam logic [4:0] LINK_ADDR_HI = 5'h19;

  typedef enum logic [1:0] {
    CCG_WRITE,
    CCG_READ_FIRST,
    CCG_READ_NEXT
  } ccg_kind_e;

  typedef struct packed {
    ccg_kind_e  kind;
    logic [7:0] addr;
    logic [7:0] data;
  } ccg_req_s;

  typedef struct packed {
    logic [7:0] data;
    logic       more;
  } ccg_rsp_s;

endpackage

/* ccg_serial_link.sv */
// two-wire serial slave on the link clock, handing byte accesses across
`timescale 1ns/1ps
module ccg_serial_link #(
  parameter logic [4:0] ADDR_HI = ccg_pkg::LINK_ADDR_HI
) (
  input  wire logic              link_clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              serial_en_i,
  input  wire logic [1:0]        slave_addr_lo_i,
  input  wire logic              sda_i,
  input  wire logic              scl_i,
  output logic                   sda_o,
  output logic                   sda_oe_n_o,
  output logic                   scl_o,
  output logic                   scl_oe_n_o,
  output ccg_pkg::ccg_req_s      req_o,
  output logic                   req_tgl_o,
  input  wire ccg_pkg::ccg_rsp_s rsp_i,
  input  wire logic              rsp_tgl_i
);
  import ccg_pkg::*;

  typedef enum logic [2:0] {
    L_IDLE, L_RX, L_ACK, L_REQ, L_TX, L_TXACK
  } ccg_link_st_e;
  typedef enum logic [1:0] {P_ADDR, P_OFS, P_DATA} ccg_phase_e;

  // ==========================================================
  // crossings: levels on two flops, pins and toggle on three
  logic [4:0] lvl_q1;
  logic [4:0] lvl_q2;
  logic [2:0] pin_q1, pin_q2, pin_q3, pin_s;
  logic       scl_q, sda_q;
  logic       lrst, lce, len;

  always_ff @(posedge link_clk_i) begin
    lvl_q1 <= {slave_addr_lo_i, serial_en_i, ce_i, rst_i};
    lvl_q2 <= lvl_q1;
  end
  assign lrst = lvl_q2[0];
  assign lce  = lvl_q2[1];
  assign len  = lvl_q2[2];

  // a change counts only once the second and third flops agree
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      pin_q1 <= 3'h3;
      pin_q2 <= 3'h3;
      pin_q3 <= 3'h3;
      pin_s  <= 3'h3;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
    end else if (lce) begin
      pin_q1 <= {rsp_tgl_i, scl_i, sda_i};
      pin_q2 <= pin_q1;
      pin_q3 <= pin_q2;
      pin_s  <= ((pin_q2 ~^ pin_q3) & pin_q3) | ((pin_q2 ^ pin_q3) & pin_s);
      scl_q  <= pin_s[1];
      sda_q  <= pin_s[0];
    end
  end

  logic start_c, stop_c, rise_c, fall_c;
  assign start_c = pin_s[1] & scl_q & sda_q & ~pin_s[0];
  assign stop_c  = pin_s[1] & scl_q & ~sda_q & pin_s[0];
  assign rise_c  = pin_s[1] & ~scl_q;
  assign fall_c  = ~pin_s[1] & scl_q;

  // ==========================================================
  // protocol engine; clock stretching covers the crossing latency
  ccg_link_st_e state_r;
  ccg_phase_e   phase_r;
  logic [7:0]   sh_r, ptr_r;
  logic [3:0]   cnt_r;
  logic         rw_r, more_r, ack_r;

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      state_r    <= L_IDLE;
      phase_r    <= P_ADDR;
      sh_r       <= 8'h00;
      ptr_r      <= 8'h00;
      cnt_r      <= 4'h0;
      rw_r       <= 1'b0;
      more_r     <= 1'b0;
      ack_r      <= 1'b0;
      sda_oe_n_o <= 1'b1;
      scl_oe_n_o <= 1'b1;
      sda_o      <= 1'b0;
      scl_o      <= 1'b0;
      req_o      <= '0;
      req_tgl_o  <= 1'b0;
    end else if (lce) begin
      if (!len || stop_c) begin
        state_r    <= L_IDLE;
        sda_oe_n_o <= 1'b1;
        scl_oe_n_o <= 1'b1;
      end else if (start_c) begin
        state_r    <= L_RX;
        phase_r    <= P_ADDR;
        cnt_r      <= 4'h0;
        sda_oe_n_o <= 1'b1;
      end else begin
        case (state_r)
          L_RX: begin
            if (rise_c) begin
              sh_r  <= {sh_r[6:0], pin_s[0]};
              cnt_r <= 4'(cnt_r + 4'h1);
            end else if (fall_c && cnt_r == LINK_BITS) begin
              cnt_r <= 4'h0;
              if (phase_r != P_ADDR || sh_r[7:1] == {ADDR_HI, lvl_q2[4:3]}) begin
                sda_oe_n_o <= 1'b0;
                state_r    <= L_ACK;
              end else begin
                state_r <= L_IDLE;
              end
              if (phase_r == P_ADDR) begin
                rw_r <= sh_r[0];
              end
              if (phase_r == P_OFS) begin
                ptr_r <= sh_r;
              end
            end
          end
          L_ACK: begin
            if (fall_c) begin
              sda_oe_n_o <= 1'b1;
              state_r    <= L_RX;
              if (phase_r == P_ADDR && rw_r) begin
                req_o      <= '{kind: CCG_READ_FIRST, addr: ptr_r, data: 8'h00};
                req_tgl_o  <= ~req_tgl_o;
                scl_oe_n_o <= 1'b0;
                state_r    <= L_REQ;
              end else if (phase_r == P_ADDR) begin
                phase_r <= P_OFS;
              end else if (phase_r == P_OFS) begin
                phase_r <= P_DATA;
              end else begin
                req_o      <= '{kind: CCG_WRITE, addr: ptr_r, data: sh_r};
                req_tgl_o  <= ~req_tgl_o;
                ptr_r      <= 8'(ptr_r + 8'h01);
                scl_oe_n_o <= 1'b0;
                state_r    <= L_REQ;
              end
            end
          end
          L_REQ: begin
            if (pin_s[2] == req_tgl_o) begin
              scl_oe_n_o <= 1'b1;
              state_r    <= L_RX;
              if (rw_r) begin
                sh_r       <= rsp_i.data;
                more_r     <= rsp_i.more;
                sda_oe_n_o <= rsp_i.data[7];
                cnt_r      <= 4'h1;
                ptr_r      <= 8'(ptr_r + 8'h01);
                state_r    <= L_TX;
              end
            end
          end
          L_TX: begin
            if (fall_c && cnt_r == LINK_BITS) begin
              sda_oe_n_o <= 1'b1;
              state_r    <= L_TXACK;
            end else if (fall_c) begin
              sda_oe_n_o <= sh_r[6];
              sh_r       <= {sh_r[6:0], 1'b0};
              cnt_r      <= 4'(cnt_r + 4'h1);
            end
          end
          L_TXACK: begin
            if (rise_c) begin
              ack_r <= ~pin_s[0];
            end else if (fall_c && ack_r && more_r) begin
              req_o      <= '{kind: CCG_READ_NEXT, addr: ptr_r, data: 8'h00};
              req_tgl_o  <= ~req_tgl_o;
              scl_oe_n_o <= 1'b0;
              state_r    <= L_REQ;
            end else if (fall_c) begin
              state_r <= L_IDLE;
            end
          end
          default: state_r <= L_IDLE;
        endcase
      end
    end
  end

endmodule

/* ccg_config_bank_asserts.sv */
// port-level assertions for the config bank
`timescale 1ns/1ps
module ccg_config_bank_asserts #(
  parameter int STORE_CYCLES = 20
) (
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic       first_output_source_sel_o,
  input wire logic [9:0] first_output_divider_o,
  input wire logic       first_output_divider_standby_o,
  input wire logic       first_clock_output_enable_o,
  input wire logic       first_clock_output_hiz_o,
  input wire logic       first_clock_output_low_o,
  input wire logic       device_power_down_o,
  input wire logic [4:0] crystal_load_code_o,
  input wire logic       nvm_store_in_progress_o
);
  import ccg_pkg::*;
  // ==========================================================
  // store length counter: store is far longer than a delay range
  localparam int STORE_MAX = STORE_CYCLES + 8;
  int busy_cnt;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !nvm_store_in_progress_o) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // properties
  src_reset_a: assert property (
    $past(rst_i) |-> first_output_source_sel_o == RST_SRC)
    else $error("source select reset value wrong");
  div_reset_a: assert property (
    $past(rst_i) |-> first_output_divider_o == RST_DIV)
    else $error("divider reset value wrong");
  cap_reset_a: assert property (
    $past(rst_i) |-> crystal_load_code_o == RST_CAP)
    else $error("load code reset value wrong");
  stby_zero_a: assert property (
    (first_output_divider_o == 10'h000) [*2]
    |-> first_output_divider_standby_o)
    else $error("standby missing for zero divider");
  stby_off_a: assert property (
    (first_output_divider_o != 10'h000) [*2]
    |-> !first_output_divider_standby_o)
    else $error("standby for nonzero divider");
  pwrdn_hiz_a: assert property (
    device_power_down_o |-> first_clock_output_hiz_o &&
    !first_clock_output_enable_o && !first_clock_output_low_o)
    else $error("power down without tristate");
  state_onehot_a: assert property (
    $onehot({first_clock_output_enable_o, first_clock_output_hiz_o,
             first_clock_output_low_o}))
    else $error("output state not one of three");
  store_max_a: assert property (
    busy_cnt <= STORE_MAX)
    else $error("store busy too long");
  store_min_a: assert property (
    $fell(nvm_store_in_progress_o) |-> $past(busy_cnt) + 8 >= STORE_CYCLES)
    else $error("store busy too short");
endmodule

bind ccg_config_bank ccg_config_bank_asserts #(
  .STORE_CYCLES(STORE_CYCLES)
) ccg_config_bank_asserts_i (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .first_output_source_sel_o(first_output_source_sel_o),
  .first_output_divider_o(first_output_divider_o),
  .first_output_divider_standby_o(first_output_divider_standby_o),
  .first_clock_output_enable_o(first_clock_output_enable_o),
  .first_clock_output_hiz_o(first_clock_output_hiz_o),
  .first_clock_output_low_o(first_clock_output_low_o),
  .device_power_down_o(device_power_down_o),
  .crystal_load_code_o(crystal_load_code_o),
  .nvm_store_in_progress_o(nvm_store_in_progress_o)
);

/* ccg_host_model.sv */
// two-wire bus host: byte writes and block reads, honours stretching
`timescale 1ns/1ps
module ccg_host_model (
  input  wire logic sda_i,
  input  wire logic scl_i,
  output logic      sda_rel_o,
  output logic      scl_rel_o
);
  import ccg_pkg::*;
  localparam int         HALF = 600;
  localparam logic [6:0] DEV  = {LINK_ADDR_HI, 2'b00};
  logic [7:0] q[$];
  initial begin
    sda_rel_o = 1'b1;
    scl_rel_o = 1'b1;
  end
  // ==========================================================
  // one bit; data moves a quarter after the fall to keep hold time
  task automatic bx(input logic b, output logic r);
    #(HALF / 2) sda_rel_o = b;
    #HALF scl_rel_o = 1'b1;
    wait (scl_i);
    #HALF r = sda_i;
    scl_rel_o = 1'b0;
  endtask
  task automatic st();
    #(HALF / 2) sda_rel_o = 1'b1;
    #HALF scl_rel_o = 1'b1;
    wait (scl_i);
    #HALF sda_rel_o = 1'b0;
    #HALF scl_rel_o = 1'b0;
  endtask
  task automatic sp();
    #(HALF / 2) sda_rel_o = 1'b0;
    #HALF scl_rel_o = 1'b1;
    wait (scl_i);
    #HALF sda_rel_o = 1'b1;
    #HALF;
  endtask
  task automatic wb(input logic [7:0] d, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) bx(d[i], r);
    bx(1'b1, ak);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic ak);
    logic r;
    st();
    wb({DEV, 1'b0}, ak);
    wb(a, r);
    wb(d, r);
    sp();
  endtask
  // last byte gets a not-acknowledge to end the read
  task automatic rd(input logic [7:0] a, input int n);
    logic       r;
    logic [7:0] d;
    q.delete();
    st();
    wb({DEV, 1'b0}, r);
    wb(a, r);
    st();
    wb({DEV, 1'b1}, r);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) bx(1'b1, d[i]);
      bx(k == n - 1, r);
      q.push_back(d);
    end
    sp();
  endtask
endmodule

/* testbench.sv */
// bench: bus host drives the bank, a byte model predicts readbacks and outputs
`timescale 1ns/1ps
module testbench;
  import ccg_pkg::*;
  localparam int SC = 6000;
  logic       sys_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       rst = 1'b1;
  logic       s0 = 1'b0;
  logic       gnd = 1'b0;
  logic       ctl = 1'b0;
  logic       bz_q = 1'b0;
  logic [7:0] m[0:7] = '{0, 0, 8'hB4, 8'h01, 8'h02, 8'h50, 8'hA0, 0};
  int         num_errors = 0;
  int         total_checks = 0;
  int         rises = 0;
  int         cyc = 0;
  int         seed = 96;
  wire        sda_rel, scl_rel, sda_oe_n, scl_oe_n, sda_w, scl_w;
  wire        src, stb, en, hiz, low, pd, sel, busy;
  wire [9:0]  div;
  wire [4:0]  cap;
  // open-drain wires with pull-ups
  assign sda_w = sda_rel & sda_oe_n;
  assign scl_w = scl_rel & scl_oe_n;
  ccg_config_bank #(.STORE_CYCLES(SC)) ccg_config_bank_i (
    .sys_clk_i(sys_clk), .rst_i(rst), .ce_i(1'b1), .link_clk_i(link_clk),
    .control_pin_zero_i(s0), .shared_data_pin_i(sda_w),
    .shared_data_pin_o(), .shared_data_pin_oe_n_o(sda_oe_n),
    .shared_clk_pin_i(scl_w), .shared_clk_pin_o(),
    .shared_clk_pin_oe_n_o(scl_oe_n), .output_supply_gnd_i(gnd),
    .first_output_source_sel_o(src), .first_output_divider_o(div),
    .first_output_divider_standby_o(stb),
    .first_clock_output_enable_o(en), .first_clock_output_hiz_o(hiz),
    .first_clock_output_low_o(low), .device_power_down_o(pd),
    .crystal_load_code_o(cap), .shared_pin_function_sel_o(sel),
    .nvm_store_in_progress_o(busy));
  ccg_host_model ccg_host_model_i (
    .sda_i(sda_w), .scl_i(scl_w), .sda_rel_o(sda_rel), .scl_rel_o(scl_rel));
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #7;
    forever #62.5 link_clk = ~link_clk;
  end
  // ==========================================================
  // store start counter and hang guard
  always @(posedge sys_clk) begin
    bz_q <= busy;
    rises <= rises + int'(busy & ~bz_q);
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      num_errors = num_errors + 1;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_outs();
    logic [2:0] ix;
    logic [1:0] c;
    logic [9:0] dv;
    ix = ctl ? {scl_w, sda_w, s0} : {2'b00, s0};
    c = m[4][ix] ? m[2][5:4] : m[2][3:2];
    dv = {m[2][1:0], m[3]};
    chk({src, div, stb, en, hiz, low, pd, cap, sel},
        {m[2][7], dv, dv == 0, c == 3, c < 2, c == 2, c == 0, m[5][7:3], ctl});
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic ak;
    ccg_host_model_i.wr(a, d, ak);
    chk(ak, ctl);
    if (!ctl) m[a[2:0]] = d;
    repeat (20) @(negedge sys_clk);
  endtask
  task automatic r(input logic [7:0] a, input int n, input int nv);
    ccg_host_model_i.rd(a, n);
    for (int i = 0; i < n; i++)
      chk(ccg_host_model_i.q[i], i < nv ? m[a[2:0] + i] : 8'hFF);
    repeat (20) @(negedge sys_clk);
  endtask
  // no bus writes until the store has finished
  task automatic idle();
    for (int i = 0; i < 8000 && busy !== 1'b0; i++) @(negedge sys_clk);
    chk(busy, 1'b0);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    repeat (40) @(negedge sys_clk);
    chk_outs();
    r(2, 6, 6);
    $display("reset values done");
    w(5, 8'($random(seed)) & 8'hF8);
    w(4, 8'($random(seed)));
    for (int c = 0; c < 4; c++) begin
      w(2, {1'($random(seed)), 1'b0, 2'(3 - c), 2'(c), 2'(c / 2)});
      if (c % 2 == 0) w(3, c == 0 ? 8'h00 : 8'($random(seed)));
      for (int k = 0; k < 2; k++) begin
        s0 = k[0];
        repeat (10) @(negedge sys_clk);
        chk_outs();
      end
    end
    $display("state decode done");
    w(6, 8'h06);
    r(2, 4, 3);
    $display("block count done");
    w(6, 8'h07);
    m[1][6] = 1'b1;
    r(1, 1, 1);
    m[1][6] = 1'b0;
    idle();
    w(6, 8'h07);
    chk(rises, 1);
    w(2, m[2] | 8'h40);
    w(1, 8'h20);
    w(6, 8'h06);
    w(6, 8'h07);
    idle();
    chk(rises, 2);
    ctl = 1'b1;
    repeat (20) @(negedge sys_clk);
    chk_outs();
    w(3, ~m[3]);
    chk_outs();
    $display("store and pin mode done");
    gnd = 1'b1;
    ctl = 1'b0;
    repeat (20) @(negedge sys_clk);
    chk_outs();
    w(6, 8'h06);
    w(6, 8'h07);
    repeat (50) @(negedge sys_clk);
    chk(rises, 2);
    gnd = 1'b0;
    ctl = 1'b1;
    for (int k = 0; k < 8; k++) begin
      {ccg_host_model_i.scl_rel_o, ccg_host_model_i.sda_rel_o, s0} = 3'(k);
      repeat (40) @(negedge sys_clk);
      chk_outs();
    end
    $display("lock and control pins done");
    wrap_up();
  end
endmodule
